/* File: rtl/dctom_regs.svh */
// Register offsets, field positions, reset values and timing counts of the torque-off monitor.
`ifndef DCTOM_REGS_SVH
`define DCTOM_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DCTOM_CTRL_ADDR 12'h000
`define DCTOM_STATUS_ADDR 12'h004
`define DCTOM_ERROR_ADDR 12'h008
`define DCTOM_ADDR_W 12

// ----------------------------------------
// Field positions and control reset value
// ----------------------------------------
`define DCTOM_CTRL_ENABLE 0
`define DCTOM_CTRL_BRAKE 1
`define DCTOM_CTRL_ACK 2
`define DCTOM_ERR_DISC 0
`define DCTOM_ERR_PLAUS_A 1
`define DCTOM_ERR_PLAUS_B 2
`define DCTOM_CTRL_RESET 32'h00000000

// ----------------------------------------
// Timing
// ----------------------------------------
`define DCTOM_CLK_HZ 100000000
`define DCTOM_TICK_US 1
`define DCTOM_TICK_CYCLES (`DCTOM_CLK_HZ / 1000000 * `DCTOM_TICK_US)
`define DCTOM_DISC_MS 100
`define DCTOM_DISC_TICKS (`DCTOM_DISC_MS * 1000 / `DCTOM_TICK_US)
`define DCTOM_PULSE_MS 4
`define DCTOM_PULSE_TICKS (`DCTOM_PULSE_MS * 1000 / `DCTOM_TICK_US)
`define DCTOM_SUPPLY_MS 20
`define DCTOM_SUPPLY_TICKS (`DCTOM_SUPPLY_MS * 1000 / `DCTOM_TICK_US)
`define DCTOM_SQW_US 1000
`define DCTOM_SQW_TICKS (`DCTOM_SQW_US / `DCTOM_TICK_US)
`define DCTOM_CNT_W 20

`endif

/* File: rtl/dctom_pkg.sv */
// Types of the torque-off monitor.
package dctom_pkg;
   typedef enum logic [1:0] {
      DCTOM_RUN,
      DCTOM_DISCREP,
      DCTOM_SAFE
   } dctom_state_e;
   typedef logic [19:0] dctom_cnt_t;
endpackage

/* File: rtl/dctom_tick.sv */
// Timebase divider giving a one-cycle tick enable.
`include "dctom_regs.svh"
module dctom_tick (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Tick output.
   output logic tick
);
   typedef struct packed {
      logic [7:0] cnt;
      logic tick;
   } dctom_tick_s;
   dctom_tick_s q;
   dctom_tick_s next_q;

   always_comb begin
      next_q = q;
      next_q.tick = 1'b0;
      if (q.cnt == 8'(`DCTOM_TICK_CYCLES - 1)) begin
         next_q.cnt = 8'h00;
         next_q.tick = 1'b1;
      end else begin
         next_q.cnt = q.cnt + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign tick = q.tick;
endmodule

/* File: rtl/dctom_filter.sv */
// Test-pulse filter: a low pulse shorter than the limit is ignored.
`include "dctom_regs.svh"
module dctom_filter (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Timebase.
   input wire logic tick,
   // Raw and filtered level.
   input wire logic raw,
   output logic level
);
   typedef struct packed {
      dctom_pkg::dctom_cnt_t cnt;
      logic level;
   } dctom_filter_s;
   dctom_filter_s q;
   dctom_filter_s next_q;

   always_comb begin
      next_q = q;
      if (raw) begin
         next_q.cnt = '0;
         next_q.level = 1'b1;
      end else if (q.level && tick) begin
         if (q.cnt >= dctom_pkg::dctom_cnt_t'(`DCTOM_PULSE_TICKS)) begin
            next_q.level = 1'b0;
         end else begin
            next_q.cnt = q.cnt + 20'h00001;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q.cnt <= '0;
         q.level <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   assign level = q.level;
endmodule

/* File: rtl/dctom_top.sv */
// Dual-channel torque-off monitor with APB register access.
//
// The APB register port and the address map are this design's own decisions.
`include "dctom_regs.svh"
// Functional notes
// - Safe state entered only when both inputs low and both feedbacks read one.
// - Unequal inputs tolerated within window; error raised once window expires.
// - Discrepancy window is one hundred milliseconds.
// - Low test pulses up to four milliseconds are ignored.
// - Feedback contact open whenever safe state is not active.
// - Feedback contact closed while safe state is active; the code also requires logic_supply_ok high.
// - Contact may disagree with inputs under twenty milliseconds at supply ramps.
// - Torque-off request disables control loop and PWM output.
// - Torque-off request stops holding brake actuation.
// - PWM feedback detects channel A blocking the PWM path.
// - Driver-supply feedback detects channel B removing driver supply.
// - Each channel checked against its feedback; implausible pairs flag hardware error.
// - Status and errors are reported on outputs and on the status and error registers.
// - One acknowledgement clears all acknowledgeable errors.
// - Request accepted at any time, also while PWM runs.
// - PWM feedback one when channel A blocked, zero when powered.
// - Driver feedback one when supply removed, otherwise a square wave.
module dctom_top (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Safety connector inputs and feedback.
   input wire logic torque_off_channel_a,
   input wire logic torque_off_channel_b,
   input wire logic pwm_feedback,
   input wire logic driver_supply_feedback,
   input wire logic logic_supply_ok,
   // Drive outputs.
   output logic feedback_contact_closed,
   output logic pwm_enable,
   output logic control_enable,
   output logic brake_release,
   output logic torque_off_status,
   output logic error_flag
);
   typedef struct packed {
      dctom_pkg::dctom_state_e state;
      dctom_pkg::dctom_cnt_t disc_cnt;
      dctom_pkg::dctom_cnt_t sqw_cnt;
      dctom_pkg::dctom_cnt_t sup_cnt;
      logic drv_prev;
      logic chb_prev;
      logic sqw_seen;
      logic [2:0] err;
      logic enable;
      logic brake;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic contact;
      logic pwm_en;
      logic ctl_en;
      logic brake_out;
      logic sto_stat;
      logic err_out;
   } dctom_top_s;
   dctom_top_s q;
   dctom_top_s next_q;

   logic tick;
   logic lvl_a;
   logic lvl_b;

   // ----------------------------------------
   // Timebase and test-pulse filters
   // ----------------------------------------
   dctom_tick u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick)
   );

   dctom_filter u_filt_a (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .raw(torque_off_channel_a),
      .level(lvl_a)
   );

   dctom_filter u_filt_b (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .raw(torque_off_channel_b),
      .level(lvl_b)
   );

   // ----------------------------------------
   // Monitor logic
   // ----------------------------------------
   logic both_low;
   logic blocked_a;
   logic removed_b;
   logic safe_now;
   logic apb_acc;
   logic ack;
   logic [31:0] rd;
   logic hit;
   logic settled;
   logic check_a;
   logic check_b;

   always_comb begin
      next_q = q;
      both_low = !lvl_a && !lvl_b;
      blocked_a = pwm_feedback;
      removed_b = driver_supply_feedback && q.sqw_seen;
      safe_now = both_low && blocked_a && removed_b;
      apb_acc = psel && penable && !q.pready;
      ack = apb_acc && pwrite && paddr == `DCTOM_CTRL_ADDR && pwdata[`DCTOM_CTRL_ACK];
      // Driver feedback steady high for a square-wave period means supply removed.
      // A rising channel B restarts the measurement, so an old steady level is not reused.
      next_q.drv_prev = driver_supply_feedback;
      next_q.chb_prev = torque_off_channel_b;
      if (driver_supply_feedback != q.drv_prev || !driver_supply_feedback
         || (torque_off_channel_b && !q.chb_prev)) begin
         next_q.sqw_cnt = '0;
         next_q.sqw_seen = 1'b0;
      end else if (tick) begin
         if (q.sqw_cnt >= dctom_pkg::dctom_cnt_t'(`DCTOM_SQW_TICKS)) begin
            next_q.sqw_seen = 1'b1;
         end else begin
            next_q.sqw_cnt = q.sqw_cnt + 20'h00001;
         end
      end
      // Plausibility is judged only where the filtered level agrees with the raw input.
      settled = q.sup_cnt >= dctom_pkg::dctom_cnt_t'(`DCTOM_SUPPLY_TICKS);
      check_a = torque_off_channel_a == lvl_a;
      check_b = torque_off_channel_b == lvl_b;
      if (check_a && lvl_a == blocked_a && settled) begin
         next_q.err[`DCTOM_ERR_PLAUS_A] = 1'b1;
      end
      if (check_b && lvl_b == removed_b && settled) begin
         next_q.err[`DCTOM_ERR_PLAUS_B] = 1'b1;
      end
      // Supply settle time masks plausibility errors during ramp.
      if (!logic_supply_ok) begin
         next_q.sup_cnt = '0;
      end else if (tick && q.sup_cnt < dctom_pkg::dctom_cnt_t'(`DCTOM_SUPPLY_TICKS)) begin
         next_q.sup_cnt = q.sup_cnt + 20'h00001;
      end
      // Channel state machine.
      case (q.state)
         dctom_pkg::DCTOM_RUN: begin
            if (lvl_a != lvl_b) begin
               next_q.state = dctom_pkg::DCTOM_DISCREP;
               next_q.disc_cnt = '0;
            end else if (safe_now) begin
               next_q.state = dctom_pkg::DCTOM_SAFE;
            end
         end
         dctom_pkg::DCTOM_DISCREP: begin
            if (lvl_a == lvl_b) begin
               next_q.state = safe_now ? dctom_pkg::DCTOM_SAFE : dctom_pkg::DCTOM_RUN;
            end else if (tick) begin
               if (q.disc_cnt >= dctom_pkg::dctom_cnt_t'(`DCTOM_DISC_TICKS)) begin
                  next_q.err[`DCTOM_ERR_DISC] = 1'b1;
               end else begin
                  next_q.disc_cnt = q.disc_cnt + 20'h00001;
               end
            end
         end
         dctom_pkg::DCTOM_SAFE: begin
            if (!safe_now) begin
               next_q.state = (lvl_a != lvl_b) ? dctom_pkg::DCTOM_DISCREP : dctom_pkg::DCTOM_RUN;
               next_q.disc_cnt = '0;
            end
         end
         default: begin
            next_q.state = dctom_pkg::DCTOM_RUN;
         end
      endcase
      // Acknowledge clears errors; a new error in the same cycle wins.
      if (ack) begin
         next_q.err = q.err & ~(3'h7) | (next_q.err & ~q.err);
      end
      // Outputs.
      next_q.contact = logic_supply_ok && next_q.state == dctom_pkg::DCTOM_SAFE;
      next_q.ctl_en = q.enable && !(lvl_a == 1'b0 || lvl_b == 1'b0) && next_q.err == 3'h0;
      next_q.pwm_en = next_q.ctl_en && !blocked_a;
      next_q.brake_out = q.brake && next_q.ctl_en;
      next_q.sto_stat = next_q.state == dctom_pkg::DCTOM_SAFE;
      next_q.err_out = next_q.err != 3'h0;
      // APB slave, one wait state.
      rd = 32'h00000000;
      hit = 1'b1;
      case (paddr)
         `DCTOM_CTRL_ADDR: rd = {30'h00000000, q.brake, q.enable};
         `DCTOM_STATUS_ADDR: rd = {24'h000000, lvl_b, lvl_a, removed_b, blocked_a, q.ctl_en, q.contact, q.state};
         `DCTOM_ERROR_ADDR: rd = {29'h00000000, q.err};
         default: hit = 1'b0;
      endcase
      next_q.pready = apb_acc;
      next_q.pslverr = apb_acc && !hit;
      if (apb_acc && !pwrite) begin
         next_q.prdata = rd;
      end
      if (apb_acc && pwrite && paddr == `DCTOM_CTRL_ADDR) begin
         next_q.enable = pwdata[`DCTOM_CTRL_ENABLE];
         next_q.brake = pwdata[`DCTOM_CTRL_BRAKE];
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign feedback_contact_closed = q.contact;
   assign pwm_enable = q.pwm_en;
   assign control_enable = q.ctl_en;
   assign brake_release = q.brake_out;
   assign torque_off_status = q.sto_stat;
   assign error_flag = q.err_out;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   contact_safe_a: assert property (@(posedge pclk) disable iff (!presetn)
      q.contact |-> q.sto_stat) else $error("Contact closed outside safe state.");
   contact_open_a: assert property (@(posedge pclk) disable iff (!presetn)
      !logic_supply_ok |=> !q.contact) else $error("Contact closed without logic supply.");
   safe_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(q.sto_stat) |-> $past(!lvl_a && !lvl_b && pwm_feedback)) else $error("Safe state without cause.");
   pwm_block_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!lvl_a || !lvl_b) |=> !q.pwm_en && !q.ctl_en) else $error("PWM still enabled on request.");
   brake_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!lvl_a || !lvl_b) |=> !q.brake_out) else $error("Brake still actuated on request.");
   disc_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
      q.err[0] && !ack |=> q.err[0]) else $error("Discrepancy error dropped without ack.");
   ack_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      ack && q.state == dctom_pkg::DCTOM_RUN && lvl_a && lvl_b && lvl_a != pwm_feedback
      && !removed_b |=> q.err == 3'h0) else $error("Ack did not clear errors.");
   err_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      q.err != 3'h0 |-> ##1 q.err_out || $past(ack)) else $error("Error flag not shown.");
   apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !q.pready |=> q.pready) else $error("APB access not answered.");
   apb_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      q.pready |=> !q.pready) else $error("Ready held longer than one cycle.");
   apb_err_a: assert property (@(posedge pclk) disable iff (!presetn)
      q.pslverr |-> q.pready) else $error("Slave error without ready.");
   rd_err_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !q.pready && !pwrite && paddr == `DCTOM_ERROR_ADDR
      |=> q.prdata == {29'h00000000, $past(q.err)}) else $error("Error register read wrong.");

   // ----------------------------------------
   // Filter, timing, latch and output-enable assertions
   // ----------------------------------------
   chan_a_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
      torque_off_channel_a |=> lvl_a) else $error("Filtered level A not restored.");
   chan_b_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
      torque_off_channel_b |=> lvl_b) else $error("Filtered level B not restored.");
   pwm_ctl_a: assert property (@(posedge pclk) disable iff (!presetn)
      q.pwm_en |-> q.ctl_en) else $error("PWM enabled without control loop.");
   brake_ctl_a: assert property (@(posedge pclk) disable iff (!presetn)
      q.brake_out |-> q.ctl_en) else $error("Brake actuated without control loop.");
   disc_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
      q.state == dctom_pkg::DCTOM_RUN && lvl_a != lvl_b |=> q.disc_cnt == 20'h00000) else $error("Window not restarted.");
   disc_early_a: assert property (@(posedge pclk) disable iff (!presetn)
      q.state == dctom_pkg::DCTOM_DISCREP && !q.err[`DCTOM_ERR_DISC]
      && q.disc_cnt < dctom_pkg::dctom_cnt_t'(`DCTOM_DISC_TICKS) |=> !q.err[`DCTOM_ERR_DISC])
      else $error("Discrepancy error before window end.");
   plaus_a_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
      q.err[`DCTOM_ERR_PLAUS_A] && !ack |=> q.err[`DCTOM_ERR_PLAUS_A]) else $error("Error A dropped without ack.");
   plaus_b_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
      q.err[`DCTOM_ERR_PLAUS_B] && !ack |=> q.err[`DCTOM_ERR_PLAUS_B]) else $error("Error B dropped without ack.");
   supply_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
      q.sup_cnt < dctom_pkg::dctom_cnt_t'(`DCTOM_SUPPLY_TICKS)
      && q.err[`DCTOM_ERR_PLAUS_B:`DCTOM_ERR_PLAUS_A] == 2'h0
      |=> q.err[`DCTOM_ERR_PLAUS_B:`DCTOM_ERR_PLAUS_A] == 2'h0) else $error("Plausibility error during ramp.");
   sqw_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
      !driver_supply_feedback |=> !q.sqw_seen) else $error("Supply removal seen on low feedback.");
   err_ctl_a: assert property (@(posedge pclk) disable iff (!presetn)
      q.err != 3'h0 |-> !q.ctl_en) else $error("Control enabled with latched error.");
endmodule

/* File: verification/dctom_safety_ctrl.sv */
// Model of the outside safety controller and the disconnection-path feedback.
module dctom_safety_ctrl (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Requested control voltage levels.
   input wire logic cmd_a,
   input wire logic cmd_b,
   // Safety connector side.
   output logic torque_off_channel_a,
   output logic torque_off_channel_b,
   output logic pwm_feedback,
   output logic driver_supply_feedback
);
   logic [9:0] div;
   logic wave;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         torque_off_channel_a <= 1'h1;
         torque_off_channel_b <= 1'h1;
         div <= 10'h000;
         wave <= 1'h0;
      end else begin
         torque_off_channel_a <= cmd_a;
         torque_off_channel_b <= cmd_b;
         div <= div + 10'h001;
         if (div == 10'h3FF) begin
            wave <= ~wave;
         end
      end
   end
   assign pwm_feedback = ~torque_off_channel_a;
   assign driver_supply_feedback = torque_off_channel_b ? wave : 1'h1;
endmodule

/* File: verification/dctom_top_tb.sv */
// Self-checking testbench of the torque-off monitor.
`include "dctom_regs.svh"
module dctom_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic pclk, presetn, psel, penable, pwrite, cmd_a, cmd_b, ch_a, ch_b, fb_pwm, fb_drv, supply_ok;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, err, contact, pwm_en, ctl_en, brake, safe, error_flag;
   int num_errors = 0;
   int total_checks = 0;
   int cycles = 0;

   dctom_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .torque_off_channel_a(ch_a), .torque_off_channel_b(ch_b), .pwm_feedback(fb_pwm),
      .driver_supply_feedback(fb_drv), .logic_supply_ok(supply_ok), .feedback_contact_closed(contact),
      .pwm_enable(pwm_en), .control_enable(ctl_en), .brake_release(brake),
      .torque_off_status(safe), .error_flag(error_flag));
   dctom_safety_ctrl ctrl (.pclk(pclk), .presetn(presetn), .cmd_a(cmd_a), .cmd_b(cmd_b),
      .torque_off_channel_a(ch_a), .torque_off_channel_b(ch_b), .pwm_feedback(fb_pwm),
      .driver_supply_feedback(fb_drv));

   // ----------------------------------------
   // Clock and timeout
   // ----------------------------------------
   initial begin
      pclk = 1'h0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 2000000) begin
         num_errors++;
         test_done();
      end
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic test_done();
      if (num_errors == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk_bit(input string name, input logic exp, input logic got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wait_contact(input logic exp, input int lim);
      int n;
      n = 0;
      while (contact !== exp && n < lim) begin
         @(negedge pclk);
         n++;
      end
      chk_bit("contact", exp, contact);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      apb(1'h0, `DCTOM_CTRL_ADDR, 32'h00000000);
      chk_word("ctrl reset", `DCTOM_CTRL_RESET, rd);
      apb(1'h1, `DCTOM_CTRL_ADDR, 32'h00000003);
      apb(1'h0, `DCTOM_CTRL_ADDR, 32'h00000000);
      chk_word("ctrl", 32'h00000003, rd);
      apb(1'h0, 12'h00C, 32'h00000000);
      chk_word("unmapped", 32'h00000000, rd);
      chk_bit("slverr", 1'h1, err);
      @(negedge pclk);
      chk_bit("pwm running", 1'h1, pwm_en);
      chk_bit("brake running", 1'h1, brake);
      chk_bit("contact idle", 1'h0, contact);
   endtask
   task automatic t_pulse();
      @(posedge pclk);
      cmd_a <= 1'h0;
      repeat (390000) @(posedge pclk);
      apb(1'h0, `DCTOM_STATUS_ADDR, 32'h00000000);
      cmd_a <= 1'h1;
      chk_bit("filtered a", 1'h1, rd[6]);
      @(negedge pclk);
      chk_bit("pulse safe", 1'h0, safe);
      chk_bit("pulse contact", 1'h0, contact);
   endtask
   task automatic t_safe();
      @(posedge pclk);
      cmd_a <= 1'h0;
      cmd_b <= 1'h0;
      repeat (300000) @(negedge pclk);
      chk_bit("early contact", 1'h0, contact);
      wait_contact(1'h1, 300000);
      chk_bit("safe", 1'h1, safe);
      chk_bit("pwm", 1'h0, pwm_en);
      chk_bit("control", 1'h0, ctl_en);
      chk_bit("brake", 1'h0, brake);
      apb(1'h0, `DCTOM_STATUS_ADDR, 32'h00000000);
      chk_word("state", 32'h00000002, {30'h00000000, rd[1:0]});
      chk_bit("pwm blocked", 1'h1, rd[4]);
      chk_bit("supply removed", 1'h1, rd[5]);
      supply_ok <= 1'h0;
      wait_contact(1'h0, 10);
      @(posedge pclk);
      supply_ok <= 1'h1;
      wait_contact(1'h1, 10);
      if (contact !== 1'h1) begin
         apb(1'h1, `DCTOM_CTRL_ADDR, 32'h00000000);
      end
      @(posedge pclk);
      cmd_a <= 1'h1;
      cmd_b <= 1'h1;
      wait_contact(1'h0, 300000);
   endtask
   task automatic t_ack();
      apb(1'h1, `DCTOM_CTRL_ADDR, 32'h00000007);
      apb(1'h0, `DCTOM_ERROR_ADDR, 32'h00000000);
      chk_word("errors", 32'h00000000, rd);
      chk_bit("error flag", 1'h0, error_flag);
      apb(1'h0, `DCTOM_CTRL_ADDR, 32'h00000000);
      chk_word("ack clears", 32'h00000003, rd);
   endtask

   initial begin
      presetn = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      cmd_a = 1'h1;
      cmd_b = 1'h1;
      supply_ok = 1'h1;
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      t_regs();
      t_pulse();
      t_safe();
      t_ack();
      test_done();
   end
endmodule
